// [logic/dtr_defs.svh]
// Register offsets, control fields, reset values and prescale masks.
`ifndef DTR_DEFS_SVH
`define DTR_DEFS_SVH

`define DTR_ADDR_W 12
`define DTR_OFF_LOAD 12'h000
`define DTR_OFF_VALUE 12'h004
`define DTR_OFF_CTRL 12'h008
`define DTR_OFF_CLR 12'h00c
`define DTR_OFF_RIS 12'h010
`define DTR_OFF_MIS 12'h014
`define DTR_OFF_BGLOAD 12'h018

`define DTR_CTRL_EN 7
`define DTR_CTRL_PERIODIC 6
`define DTR_CTRL_IRQEN 5
`define DTR_CTRL_PRE_HI 3
`define DTR_CTRL_PRE_LO 2
`define DTR_CTRL_WIDE 1
`define DTR_CTRL_SINGLE_RUN_SELECT 0
`define DTR_CTRL_WMASK 8'hef

`define DTR_LOAD_RST 32'h0000_0000
`define DTR_VALUE_RST 32'hffff_ffff
`define DTR_CTRL_RST 8'h20

`define DTR_PRE_MASK_1 8'h00
`define DTR_PRE_MASK_16 8'h0f
`define DTR_PRE_MASK_256 8'hff

`endif

// [logic/dtr_pkg.sv]
// Types shared by the dual decrement timer logic.
package dtr_pkg;

  typedef enum logic [1:0] {
    DTR_PRE_DIV1 = 2'h0,
    DTR_PRE_DIV16 = 2'h1,
    DTR_PRE_DIV256 = 2'h2,
    DTR_PRE_UNDEF = 2'h3
  } dtr_prescale_e;

  typedef struct packed {
    logic count_enable;
    logic periodic_select;
    logic irq_mask_enable;
    logic reserved;
    dtr_prescale_e prescale_select;
    logic width_select;
    logic single_run_select;
  } dtr_ctrl_s;

endpackage : dtr_pkg

// [logic/dtr_timer.sv]
// One decrementing timer with its APB register file.
//
// Implementation choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "dtr_defs.svh"

module dtr_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DTR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_clock,
  input wire logic count_clock_qualifier,
  output logic irq_output
);

  //////////////////////////////////////////////////////////////////////////
  // Count clock and qualifier sampling.

  logic cc_s1_q;
  logic cc_s2_q;
  logic cc_s3_q;
  logic qual_s1_q;
  logic qual_s2_q;
  logic tick_edge;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cc_s1_q <= 1'b0;
      cc_s2_q <= 1'b0;
      cc_s3_q <= 1'b0;
      qual_s1_q <= 1'b0;
      qual_s2_q <= 1'b0;
    end
    else
    begin
      cc_s1_q <= count_clock;
      cc_s2_q <= cc_s1_q;
      cc_s3_q <= cc_s2_q;
      qual_s1_q <= count_clock_qualifier;
      qual_s2_q <= qual_s1_q;
    end
  end

  // A qualified count edge is a synchronised rise with the qualifier high.
  assign tick_edge = cc_s2_q & ~cc_s3_q & qual_s2_q;

  //////////////////////////////////////////////////////////////////////////
  // Timer state and register file.

  logic [31:0] load_q;
  logic [31:0] load_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  dtr_pkg::dtr_ctrl_s ctrl_q;
  dtr_pkg::dtr_ctrl_s ctrl_d;
  logic raw_q;
  logic raw_d;
  logic pend_q;
  logic pend_d;
  logic [7:0] pre_q;
  logic [7:0] pre_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic err_q;
  logic err_d;

  logic wr_acc;
  logic rd_setup;
  logic wr_load;
  logic wr_bg;
  logic wr_clr;
  logic mapped;
  logic zero_w;
  logic dec_zero;
  logic pre_hit;
  logic count_tick;
  logic raw_set;
  logic [7:0] pre_mask;
  logic [31:0] dec_val;
  logic [31:0] wrap_val;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable;
  assign wr_load = wr_acc & (paddr == `DTR_OFF_LOAD);
  assign wr_bg = wr_acc & (paddr == `DTR_OFF_BGLOAD);
  assign wr_clr = wr_acc & (paddr == `DTR_OFF_CLR);
  assign mapped = (paddr == `DTR_OFF_LOAD) | (paddr == `DTR_OFF_VALUE) |
                  (paddr == `DTR_OFF_CTRL) | (paddr == `DTR_OFF_CLR) |
                  (paddr == `DTR_OFF_RIS) | (paddr == `DTR_OFF_MIS) |
                  (paddr == `DTR_OFF_BGLOAD);

  // width select picks 16 or 32 bits
  assign zero_w = ctrl_q.width_select ? (count_q == 32'h0000_0000) :
                  (count_q[15:0] == 16'h0000);
  assign dec_val = ctrl_q.width_select ? (count_q - 32'h0000_0001) :
                   {count_q[31:16], count_q[15:0] - 16'h0001};
  assign dec_zero = ctrl_q.width_select ? (dec_val == 32'h0000_0000) :
                    (dec_val[15:0] == 16'h0000);

  always_comb
  begin
    case (ctrl_q.prescale_select)
      dtr_pkg::DTR_PRE_DIV16: pre_mask = `DTR_PRE_MASK_16;
      dtr_pkg::DTR_PRE_DIV256: pre_mask = `DTR_PRE_MASK_256;
      default: pre_mask = `DTR_PRE_MASK_1;
    endcase
  end
  assign pre_hit = (pre_q & pre_mask) == pre_mask;

  assign count_tick = tick_edge & ~pend_q & ctrl_q.count_enable & pre_hit;

  // reload or wrap value at zero
  always_comb
  begin
    if (ctrl_q.periodic_select)
      wrap_val = ctrl_q.width_select ? load_q :
                 {count_q[31:16], load_q[15:0]};
    else
      wrap_val = ctrl_q.width_select ? 32'hffff_ffff :
                 {count_q[31:16], 16'hffff};
  end

  always_comb
  begin
    load_d = load_q;
    count_d = count_q;
    ctrl_d = ctrl_q;
    pend_d = pend_q;
    pre_d = pre_q;
    rdata_d = rdata_q;
    err_d = err_q;
    raw_set = 1'b0;
    if (tick_edge)
    begin
      if (pend_q)
      begin
        pend_d = 1'b0;
        pre_d = 8'h00;
        raw_set = zero_w;
      end
      else if (ctrl_q.count_enable)
      begin
        pre_d = pre_hit ? 8'h00 : pre_q + 8'h01;
      end
    end
    if (count_tick)
    begin
      if (zero_w)
      begin
        if (!ctrl_q.single_run_select)
        begin
          count_d = wrap_val;
          raw_set = ctrl_q.width_select ? (wrap_val == 32'h0000_0000) :
                    (wrap_val[15:0] == 16'h0000);
        end
      end
      else
      begin
        count_d = dec_val;
        raw_set = dec_zero;
      end
    end
    if (wr_load)
    begin
      load_d = pwdata;
      count_d = pwdata;
      pend_d = 1'b1;
    end
    if (wr_bg)
      load_d = pwdata;
    if (wr_acc && paddr == `DTR_OFF_CTRL)
      ctrl_d = dtr_pkg::dtr_ctrl_s'(pwdata[7:0] & `DTR_CTRL_WMASK);
    if (rd_setup)
    begin
      err_d = ~mapped;
      case (paddr)
        // load reads the next reload value
        `DTR_OFF_LOAD: rdata_d = load_q;
        `DTR_OFF_VALUE: rdata_d = count_q;
        `DTR_OFF_CTRL: rdata_d = {24'h00_0000, ctrl_q};
        `DTR_OFF_RIS: rdata_d = {31'h0000_0000, raw_q};
        `DTR_OFF_MIS: rdata_d = {31'h0000_0000, irq_output};
        `DTR_OFF_BGLOAD: rdata_d = load_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // clear acts at once in the bus domain
  // any clear write clears; a set in the same cycle wins
  assign raw_d = raw_set | (raw_q & ~wr_clr);

  // control reset value enables the interrupt
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_q <= `DTR_LOAD_RST;
      count_q <= `DTR_VALUE_RST;
      ctrl_q <= dtr_pkg::dtr_ctrl_s'(`DTR_CTRL_RST);
      raw_q <= 1'b0;
      pend_q <= 1'b0;
      pre_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else
    begin
      load_q <= load_d;
      count_q <= count_d;
      ctrl_q <= ctrl_d;
      raw_q <= raw_d;
      pend_q <= pend_d;
      pre_q <= pre_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
    end
  end

  assign prdata = rdata_q;
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_q;

  assign irq_output = raw_q & ctrl_q.irq_mask_enable;

  //////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_load_wr;
    wr_load;
  endsequence

  sequence s_bg_wr;
    wr_bg && !wr_load;
  endsequence

  sequence s_zero_hit;
    count_tick && !zero_w && dec_zero && !wr_load;
  endsequence

  load_view_a: assert property (
    s_load_wr |=> count_q == $past(pwdata) && pend_q)
    else $error("direct load not visible at once");

  pend_apply_a: assert property (
    pend_q && tick_edge && !wr_load |=> !pend_q)
    else $error("direct load not applied on qualified edge");

  bg_keep_a: assert property (
    s_bg_wr ##0 !count_tick |=> count_q == $past(count_q))
    else $error("background write changed the count");

  both_load_a: assert property (
    s_load_wr ##1 (!tick_edge) [*2] ##1 s_bg_wr ##0 !tick_edge |=>
      count_q == $past(count_q) && load_q == $past(pwdata) && pend_q)
    else $error("direct and background loads mixed up");

  zero_irq_a: assert property (
    s_zero_hit |=> raw_q ##1 (raw_q || $past(wr_clr)))
    else $error("zero reached without raw interrupt");

  clear_irq_a: assert property (
    wr_clr && !raw_set |=> !irq_output && !raw_q)
    else $error("clear write did not drop interrupt");

  mask_irq_a: assert property (
    !ctrl_q.irq_mask_enable |-> !irq_output)
    else $error("masked interrupt reached output");

  hold_dis_a: assert property (
    !ctrl_q.count_enable && !wr_load |=> count_q == $past(count_q))
    else $error("disabled counter moved");

  upper_keep_a: assert property (
    !ctrl_q.width_select && !wr_load |=>
      count_q[31:16] == $past(count_q[31:16]))
    else $error("upper half changed in 16-bit mode");

  single_run_select_halt_a: assert property (
    ctrl_q.single_run_select && zero_w && !wr_load |=>
      count_q == $past(count_q))
    else $error("one-shot counter left zero");

  wrap_free_a: assert property (
    count_tick && zero_w && ctrl_q.width_select &&
    !ctrl_q.periodic_select && !ctrl_q.single_run_select && !wr_load
    |=> count_q == 32'hffff_ffff)
    else $error("free-running counter did not wrap");

  zero_load_a: assert property (
    pend_q && tick_edge && zero_w |=> raw_q)
    else $error("zero load did not interrupt");

  set_wins_a: assert property (
    raw_set |=> raw_q)
    else $error("raw status set lost to a clear");

  reserved_zero_a: assert property (
    !ctrl_q.reserved)
    else $error("reserved control bit became set");

  pre_restart_a: assert property (
    pend_q && tick_edge |=> pre_q == 8'h00)
    else $error("prescaler not restarted by direct load");

  pre_wait_a: assert property (
    tick_edge && ctrl_q.count_enable && !pend_q && !pre_hit &&
    !wr_load |=> count_q == $past(count_q))
    else $error("count moved before prescale period");

  value_read_a: assert property (
    rd_setup && paddr == `DTR_OFF_VALUE |=> prdata == $past(count_q))
    else $error("current value read wrong");

  load_read_a: assert property (
    rd_setup && (paddr == `DTR_OFF_LOAD || paddr == `DTR_OFF_BGLOAD)
    |=> prdata == $past(load_q))
    else $error("load register reads differ");

  mis_read_a: assert property (
    rd_setup && paddr == `DTR_OFF_MIS |=>
      prdata == {31'h0000_0000, $past(irq_output)})
    else $error("masked status read wrong");

endmodule : dtr_timer

// [bench/tb_dual_decrement_timer_regs.sv]
// Self-checking testbench for the decrementing timer and its registers.
`timescale 1ns/100ps
`include "dtr_defs.svh"

`define CHK(a, e) \
  begin \
    n_tests++; \
    if ((a) !== (e)) \
    begin \
      fail_count++; \
      $display("ERROR t=%0t got %h exp %h", $time, a, e); \
    end \
  end

module tb_dual_decrement_timer_regs;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [`DTR_ADDR_W-1:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic count_clock;
  logic count_clock_qualifier;
  logic irq_output;
  logic err_q;
  logic [31:0] v;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  int fail_count;
  int n_tests;
  int seed;
  int d;

  dtr_timer dut (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .count_clock(count_clock),
    .count_clock_qualifier(count_clock_qualifier),
    .irq_output(irq_output)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] dat);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] dat);
    xfer(1'b1, a, dat);
  endtask : wr

  // The expected word is queued; the monitor compares it on completion.
  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    xfer(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic tk(input int n, input logic q);
    repeat (n)
    begin
      count_clock <= 1'b1;
      count_clock_qualifier <= q;
      repeat (3) @(posedge pclk);
      count_clock <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : tk

  // disable before reconfiguring
  // Stops the counter, loads it, sets the mode and lets the load land.
  task automatic cfg(input logic [31:0] l, input logic [31:0] c);
    wr(`DTR_OFF_CTRL, 32'h0000_0000);
    wr(`DTR_OFF_LOAD, l);
    wr(`DTR_OFF_CTRL, c);
    tk(1, 1'b1);
  endtask : cfg

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask : tend

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk)
  begin
    if (psel & penable & pready & ~pwrite)
    begin
      if (exp_q.size() == 0)
        `CHK(prdata, 32'hxxxx_xxxx)
      else
      begin
        e = exp_q.pop_front();
        `CHK(prdata, e)
      end
    end
  end

  initial
  begin
    repeat (30000) @(posedge pclk);
    fail_count++;
    give_verdict();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    count_clock = 1'b0;
    count_clock_qualifier = 1'b0;
    seed = 95025;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`DTR_OFF_LOAD, 32'h0000_0000);
    rd(`DTR_OFF_VALUE, 32'hffff_ffff);
    rd(`DTR_OFF_CTRL, 32'h0000_0020);
    `CHK(err_q, 1'b0)
    rd(`DTR_OFF_RIS, 32'h0000_0000);
    rd(`DTR_OFF_MIS, 32'h0000_0000);
    rd(`DTR_OFF_BGLOAD, 32'h0000_0000);
    rd(12'h01c, 32'h0000_0000);
    `CHK(err_q, 1'b1)
    wr(`DTR_OFF_CTRL, 32'hffff_ff12);
    rd(`DTR_OFF_CTRL, 32'h0000_0002);
    tend("reset");
    v = $random(seed) | 32'h0000_0001;
    wr(`DTR_OFF_LOAD, v);
    rd(`DTR_OFF_VALUE, v);
    wr(`DTR_OFF_VALUE, 32'h0000_0000);
    rd(`DTR_OFF_VALUE, v);
    rd(`DTR_OFF_LOAD, v);
    tend("load");
    cfg(32'h0000_0003, 32'h0000_00a3);
    tk(2, 1'b1);
    `CHK(irq_output, 1'b0)
    tk(3, 1'b1);
    `CHK(irq_output, 1'b1)
    rd(`DTR_OFF_VALUE, 32'h0000_0000);
    wr(`DTR_OFF_CTRL, 32'h0000_0083);
    `CHK(irq_output, 1'b0)
    rd(`DTR_OFF_MIS, 32'h0000_0000);
    rd(`DTR_OFF_RIS, 32'h0000_0001);
    wr(`DTR_OFF_CLR, $random(seed));
    rd(`DTR_OFF_RIS, 32'h0000_0000);
    tend("one_shot");
    cfg(32'h0000_0001, 32'h0000_00a2);
    tk(1, 1'b1);
    `CHK(irq_output, 1'b1)
    tk(1, 1'b1);
    rd(`DTR_OFF_VALUE, 32'hffff_ffff);
    wr(`DTR_OFF_CLR, 32'h0000_0000);
    `CHK(irq_output, 1'b0)
    wr(`DTR_OFF_CTRL, 32'h0000_0022);
    tk(3, 1'b1);
    rd(`DTR_OFF_VALUE, 32'hffff_ffff);
    wr(`DTR_OFF_CTRL, 32'h0000_00a2);
    tk(2, 1'b0);
    rd(`DTR_OFF_VALUE, 32'hffff_ffff);
    tk(1, 1'b1);
    rd(`DTR_OFF_VALUE, 32'hffff_fffe);
    tend("wrap_hold");
    wr(`DTR_OFF_CTRL, 32'h0000_0000);
    wr(`DTR_OFF_LOAD, 32'h0000_0002);
    wr(`DTR_OFF_BGLOAD, 32'h0000_0005);
    rd(`DTR_OFF_LOAD, 32'h0000_0005);
    rd(`DTR_OFF_BGLOAD, 32'h0000_0005);
    rd(`DTR_OFF_VALUE, 32'h0000_0002);
    wr(`DTR_OFF_CTRL, 32'h0000_00e2);
    tk(4, 1'b1);
    rd(`DTR_OFF_VALUE, 32'h0000_0005);
    wr(`DTR_OFF_BGLOAD, 32'h0000_0007);
    rd(`DTR_OFF_VALUE, 32'h0000_0005);
    tk(6, 1'b1);
    rd(`DTR_OFF_VALUE, 32'h0000_0007);
    wr(`DTR_OFF_CLR, 32'h0000_0000);
    `CHK(irq_output, 1'b0)
    tend("periodic");
    cfg(32'h1234_0002, 32'h0000_00a1);
    tk(2, 1'b1);
    rd(`DTR_OFF_VALUE, 32'h1234_0000);
    `CHK(irq_output, 1'b1)
    wr(`DTR_OFF_CLR, 32'h0000_0000);
    wr(`DTR_OFF_CTRL, 32'h0000_0000);
    wr(`DTR_OFF_LOAD, 32'h1234_0001);
    wr(`DTR_OFF_BGLOAD, 32'h5678_0002);
    wr(`DTR_OFF_CTRL, 32'h0000_00e0);
    tk(3, 1'b1);
    rd(`DTR_OFF_VALUE, 32'h1234_0002);
    wr(`DTR_OFF_CTRL, 32'h0000_0020);
    wr(`DTR_OFF_CTRL, 32'h0000_00a0);
    tk(3, 1'b1);
    rd(`DTR_OFF_VALUE, 32'h1234_ffff);
    wr(`DTR_OFF_CLR, 32'h0000_0000);
    tend("narrow");
    for (int i = 0; i < 3; i++)
    begin
      d = (i == 0) ? 1 : (i == 1) ? 16 : 256;
      cfg(32'h0000_0002, 32'h0000_0082 | (i << 2));
      tk(d - 1, 1'b1);
      rd(`DTR_OFF_VALUE, 32'h0000_0002);
      tk(1, 1'b1);
      rd(`DTR_OFF_VALUE, 32'h0000_0001);
    end
    tend("prescale");
    `CHK(irq_output, 1'b0)
    cfg(32'h0000_0000, 32'h0000_00a3);
    `CHK(irq_output, 1'b1)
    rd(`DTR_OFF_RIS, 32'h0000_0001);
    tend("zero_load");
    give_verdict();
  end
endmodule : tb_dual_decrement_timer_regs
